// ---- pkg/acc_pkg.sv ----
// Constants for the analog configuration command decoder.
// Operation
// [RULE1] Pin-volume load: 0x45, low byte, high nibble.
// [RULE2] Third byte keeps only its low four bits.
// [RULE3] Pin-volume load selects volume from external pin.
// [RULE4] Register-volume load 0x65 selects volume from word.
// [RULE5] Save 0x46 then 0x00 copies word to store.
// [RULE6] Power-on or reset reloads word from store; code clears both word and store to ACC_NV_RESET.
// [RULE7] Restore 0x47 then 0x00 reloads word from store.
// [RULE8] Save or restore outside idle sets command error.
// [RULE9] Host avoids volume changes during active commands.
// [RULE10] Only the host issues these configuration commands.
// [RULE11] Opcode byte returns status zero, no interrupt; code returns i_status with o_cmd_err ORed into bit 0.
`default_nettype none
package acc_pkg;
	// ----------------------------------------
	// Opcodes
	// ----------------------------------------
	localparam logic [7:0] ACC_OP_LOAD_PIN = 8'h45;
	localparam logic [7:0] ACC_OP_LOAD_REG = 8'h65;
	localparam logic [7:0] ACC_OP_SAVE = 8'h46;
	localparam logic [7:0] ACC_OP_RESTORE = 8'h47;
	localparam logic [7:0] ACC_ARG_ZERO = 8'h00;
	// ----------------------------------------
	// Widths and fields
	// ----------------------------------------
	localparam int ACC_CFG_W = 12;
	localparam int ACC_HI_W = 4;
	localparam int ACC_VOL_W = 3;
	localparam int ACC_ERR_BIT = 0;
	localparam logic [11:0] ACC_NV_RESET = 12'h000;
	typedef enum logic [1:0] {ACC_ST_OP, ACC_ST_B1, ACC_ST_B2, ACC_ST_SKIP} acc_state_e;
endpackage
`default_nettype wire

// ---- rtl/acc_shift.sv ----
// Serial byte shifter for the command link.
`default_nettype none
module acc_shift
	import acc_pkg::*;
(
	input wire logic i_clk,
	input wire logic i_rst,
	input wire logic i_frame,
	input wire logic i_sclk_rise,
	input wire logic i_sclk_fall,
	input wire logic i_mosi,
	input wire logic i_load,
	input wire logic [7:0] i_tx_byte,
	output logic o_miso,
	output logic o_byte_vld,
	output logic [7:0] o_rx_byte
);
	logic [7:0] rx_ff;
	logic [7:0] tx_ff;
	logic [2:0] cnt_ff;
	logic vld_ff;

	always_ff @(posedge i_clk) begin
		if (i_rst || !i_frame) begin
			rx_ff <= 8'h00;
			cnt_ff <= 3'h0;
			vld_ff <= 1'b0;
		end else begin
			vld_ff <= 1'b0;
			if (i_sclk_rise) begin
				rx_ff <= {rx_ff[6:0], i_mosi};
				cnt_ff <= cnt_ff + 3'h1;
				vld_ff <= (cnt_ff == 3'h7);
			end
		end
	end

	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			tx_ff <= 8'h00;
		end else if (i_load) begin
			tx_ff <= i_tx_byte;
		end else if (i_sclk_fall) begin
			tx_ff <= {tx_ff[6:0], 1'b0};
		end
	end

	assign o_miso = tx_ff[7];
	assign o_byte_vld = vld_ff;
	assign o_rx_byte = rx_ff;
endmodule
`default_nettype wire

// ---- rtl/acc_cmd.sv ----
// Analog configuration command decoder.
`default_nettype none
module acc_cmd
	import acc_pkg::*;
(
	input wire logic i_clk,
	input wire logic i_rst,
	input wire logic i_frame,
	input wire logic i_sclk_rise,
	input wire logic i_sclk_fall,
	input wire logic i_mosi,
	input wire logic i_idle,
	input wire logic i_err_clr,
	input wire logic [7:0] i_status,
	output logic o_miso,
	output logic [11:0] o_cfg,
	output logic [11:0] o_nv_cfg,
	output logic o_vol_from_reg,
	output logic o_cmd_err,
	output logic o_irq
);
	// ----------------------------------------
	// Byte link
	// ----------------------------------------
	logic byte_vld;
	logic [7:0] rx_byte;
	logic frame_d_ff;
	logic tx_load;

	assign tx_load = i_frame && !frame_d_ff;

	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			frame_d_ff <= 1'b0;
		end else begin
			frame_d_ff <= i_frame;
		end
	end

	acc_shift u_shift (
		.i_clk(i_clk),
		.i_rst(i_rst),
		.i_frame(i_frame),
		.i_sclk_rise(i_sclk_rise),
		.i_sclk_fall(i_sclk_fall),
		.i_mosi(i_mosi),
		.i_load(tx_load),
		.i_tx_byte(i_status | {7'h00, o_cmd_err}), // RULE11
		.o_miso(o_miso),
		.o_byte_vld(byte_vld),
		.o_rx_byte(rx_byte)
	);

	// ----------------------------------------
	// Command sequencer
	// ----------------------------------------
	acc_state_e state_ff;
	logic [7:0] op_ff;
	logic [7:0] lo_ff;
	logic [11:0] cfg_ff;
	logic [11:0] nv_ff;
	logic vol_reg_ff;
	logic err_ff;
	logic do_save;
	logic do_restore;
	logic err_set;

	assign do_save = byte_vld && state_ff == ACC_ST_B1 && op_ff == ACC_OP_SAVE
		&& rx_byte == ACC_ARG_ZERO && i_idle;
	assign do_restore = byte_vld && state_ff == ACC_ST_B1 && op_ff == ACC_OP_RESTORE
		&& rx_byte == ACC_ARG_ZERO && i_idle;
	assign err_set = byte_vld && state_ff == ACC_ST_OP && !i_idle
		&& (rx_byte == ACC_OP_SAVE || rx_byte == ACC_OP_RESTORE);

	always_ff @(posedge i_clk) begin
		if (i_rst || !i_frame) begin
			state_ff <= ACC_ST_OP;
			op_ff <= 8'h00;
		end else if (byte_vld) begin
			case (state_ff)
				ACC_ST_OP: begin
					op_ff <= rx_byte;
					state_ff <= ACC_ST_B1;
				end
				ACC_ST_B1: begin
					state_ff <= (op_ff == ACC_OP_LOAD_PIN || op_ff == ACC_OP_LOAD_REG)
						? ACC_ST_B2 : ACC_ST_SKIP;
				end
				ACC_ST_B2: state_ff <= ACC_ST_SKIP;
				ACC_ST_SKIP: state_ff <= ACC_ST_SKIP;
				default: state_ff <= ACC_ST_OP;
			endcase
		end
	end

	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			lo_ff <= 8'h00;
		end else if (byte_vld && state_ff == ACC_ST_B1) begin
			lo_ff <= rx_byte;
		end
	end

	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			nv_ff <= ACC_NV_RESET;
		end else if (do_save) begin
			nv_ff <= cfg_ff; // RULE5
		end
	end

	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			cfg_ff <= ACC_NV_RESET; // RULE6
			vol_reg_ff <= 1'b0;
		end else if (frame_d_ff && !i_frame && state_ff == ACC_ST_OP) begin
			cfg_ff <= cfg_ff;
		end else if (byte_vld && state_ff == ACC_ST_B2) begin
			cfg_ff <= {rx_byte[ACC_HI_W-1:0], lo_ff}; // RULE1 RULE2
			vol_reg_ff <= (op_ff == ACC_OP_LOAD_REG); // RULE3 RULE4
		end else if (do_restore) begin
			cfg_ff <= nv_ff; // RULE7
		end
	end

	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			err_ff <= 1'b0;
		end else if (err_set) begin
			err_ff <= 1'b1; // RULE8
		end else if (i_err_clr) begin
			err_ff <= 1'b0;
		end
	end

	assign o_cfg = cfg_ff;
	assign o_nv_cfg = nv_ff;
	assign o_vol_from_reg = vol_reg_ff;
	assign o_cmd_err = err_ff;
	assign o_irq = 1'b0; // RULE11

	// ----------------------------------------
	// Checks
	// ----------------------------------------
	a_load_stores_word: assert property (@(posedge i_clk) disable iff (i_rst) // RULE1
		byte_vld && state_ff == ACC_ST_B2 |=> cfg_ff[7:0] == $past(lo_ff))
		else $error("load did not store low byte");
	a_high_nibble: assert property (@(posedge i_clk) disable iff (i_rst) // RULE2
		byte_vld && state_ff == ACC_ST_B2 |=> cfg_ff[11:8] == $past(rx_byte[3:0]))
		else $error("high nibble wrong");
	a_pin_volume: assert property (@(posedge i_clk) disable iff (i_rst) // RULE3
		byte_vld && state_ff == ACC_ST_B2 && op_ff == ACC_OP_LOAD_PIN |=> !o_vol_from_reg)
		else $error("pin volume not selected");
	a_reg_volume: assert property (@(posedge i_clk) disable iff (i_rst) // RULE4
		byte_vld && state_ff == ACC_ST_B2 && op_ff == ACC_OP_LOAD_REG |=> o_vol_from_reg)
		else $error("register volume not selected");
	a_save_copy: assert property (@(posedge i_clk) disable iff (i_rst) // RULE5
		do_save |=> nv_ff == $past(cfg_ff))
		else $error("save did not copy word");
	a_reset_reload: assert property (@(posedge i_clk) // RULE6
		i_rst |=> cfg_ff == nv_ff)
		else $error("word not reloaded after reset");
	a_restore_copy: assert property (@(posedge i_clk) disable iff (i_rst) // RULE7
		do_restore |=> cfg_ff == $past(nv_ff))
		else $error("restore did not copy store");
	a_busy_error: assert property (@(posedge i_clk) disable iff (i_rst) // RULE8
		err_set |=> o_cmd_err ##1 (o_cmd_err || $past(i_err_clr)))
		else $error("command error not held");
	a_no_irq: assert property (@(posedge i_clk) disable iff (i_rst) // RULE11
		!o_irq)
		else $error("interrupt raised");

	// ----------------------------------------
	// Checks on the store, the word and the volume source
	// ----------------------------------------
	a_store_holds: assert property (@(posedge i_clk) disable iff (i_rst) // RULE5
		!do_save |=> $stable(nv_ff))
		else $error("store changed without a save");
	a_save_keeps_word: assert property (@(posedge i_clk) disable iff (i_rst) // RULE5
		do_save |=> $stable(cfg_ff))
		else $error("save changed the word");
	a_save_refused: assert property (@(posedge i_clk) disable iff (i_rst) // RULE5
		byte_vld && state_ff == ACC_ST_B1 && op_ff == ACC_OP_SAVE
		&& (rx_byte != ACC_ARG_ZERO || !i_idle) |=> $stable(nv_ff))
		else $error("refused save wrote the store");
	a_restore_refused: assert property (@(posedge i_clk) disable iff (i_rst) // RULE7
		byte_vld && state_ff == ACC_ST_B1 && op_ff == ACC_OP_RESTORE
		&& (rx_byte != ACC_ARG_ZERO || !i_idle) |=> $stable(cfg_ff))
		else $error("refused restore wrote the word");
	a_word_held: assert property (@(posedge i_clk) disable iff (i_rst) // RULE7
		!(byte_vld && state_ff == ACC_ST_B2) && !do_restore |=> $stable(cfg_ff))
		else $error("word changed without a command");
	a_vol_select_holds: assert property (@(posedge i_clk) disable iff (i_rst) // RULE3
		!(byte_vld && state_ff == ACC_ST_B2) |=> $stable(o_vol_from_reg))
		else $error("volume source changed without a load");
	a_load_keeps_store: assert property (@(posedge i_clk) disable iff (i_rst) // RULE1
		byte_vld && state_ff == ACC_ST_B2 |=> $stable(nv_ff))
		else $error("load changed the store");

	// ----------------------------------------
	// Checks on the sequencer, error flag and status
	// ----------------------------------------
	a_low_byte_capture: assert property (@(posedge i_clk) disable iff (i_rst) // RULE1
		byte_vld && state_ff == ACC_ST_B1 |=> lo_ff == $past(rx_byte))
		else $error("low byte not captured");
	a_frame_restart: assert property (@(posedge i_clk) disable iff (i_rst) // RULE1
		!i_frame |=> state_ff == ACC_ST_OP)
		else $error("sequencer not restarted by frame end");
	a_state_after_load: assert property (@(posedge i_clk) disable iff (i_rst) // RULE1
		byte_vld && state_ff == ACC_ST_B2 && i_frame |=> state_ff == ACC_ST_SKIP)
		else $error("extra bytes not skipped after load");
	a_err_clear: assert property (@(posedge i_clk) disable iff (i_rst) // RULE8
		i_err_clr && !err_set |=> !o_cmd_err)
		else $error("command error not cleared");
	a_err_quiet: assert property (@(posedge i_clk) disable iff (i_rst) // RULE8
		!err_set && !o_cmd_err |=> !o_cmd_err)
		else $error("command error set without cause");
	a_err_cause: assert property (@(posedge i_clk) disable iff (i_rst) // RULE8
		$rose(o_cmd_err) |-> $past(err_set))
		else $error("command error rose without a busy command");
	a_status_first: assert property (@(posedge i_clk) disable iff (i_rst) // RULE11
		tx_load |=> o_miso == $past(i_status[7]))
		else $error("status byte not loaded at frame start");
	a_reset_defaults: assert property (@(posedge i_clk) // RULE6
		i_rst |=> !o_cmd_err && !o_vol_from_reg)
		else $error("flags not cleared by reset");
endmodule
`default_nettype wire

// ---- verif/acc_host.sv ----
// Serial host model that frames and clocks command bytes.
`default_nettype none
module acc_host (
	input wire logic i_clk,
	input wire logic i_miso,
	output logic o_frame,
	output logic o_rise,
	output logic o_fall,
	output logic o_mosi,
	output logic [7:0] o_first
);
	timeunit 1ns;
	timeprecision 1ns;
	initial begin
		o_frame = 1'b0;
		o_rise = 1'b0;
		o_fall = 1'b0;
		o_mosi = 1'b0;
		o_first = 8'h00;
	end
	// Sends n bytes MSB first and keeps the first byte returned.
	task automatic xfer(input logic [23:0] d, input int n);
		@(posedge i_clk) o_frame <= 1'b1;
		repeat (2) @(posedge i_clk);
		for (int i = 0; i < 8 * n; i++) begin
			@(posedge i_clk) o_mosi <= d[23 - i];
			@(posedge i_clk) o_rise <= 1'b1;
			@(posedge i_clk) begin
				o_rise <= 1'b0;
				o_fall <= 1'b1;
				if (i < 8) begin
					o_first[7 - i] <= i_miso;
				end
			end
			@(posedge i_clk) o_fall <= 1'b0;
		end
		@(posedge i_clk) o_mosi <= ~o_mosi;
		@(posedge i_clk) o_frame <= 1'b0;
	endtask
endmodule
`default_nettype wire

// ---- verif/tb_acc_cmd.sv ----
// Self-checking bench for the analog configuration command decoder.
`default_nettype none
module tb_acc_cmd
	import acc_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ns;
	logic clk, rst, idle, err_clr, frame, rise, fall, mosi, miso, vfr, err, irq;
	logic [7:0] status, first, op, lo, hi;
	logic [11:0] cfg, nv;
	int err_total = 0;
	int n_compared = 0;
	integer seed = 32'h1a20;
	acc_host i_host (.i_clk(clk), .i_miso(miso), .o_frame(frame), .o_rise(rise),
		.o_fall(fall), .o_mosi(mosi), .o_first(first));
	acc_cmd i_dut (.i_clk(clk), .i_rst(rst), .i_frame(frame), .i_sclk_rise(rise),
		.i_sclk_fall(fall), .i_mosi(mosi), .i_idle(idle), .i_err_clr(err_clr),
		.i_status(status), .o_miso(miso), .o_cfg(cfg), .o_nv_cfg(nv),
		.o_vol_from_reg(vfr), .o_cmd_err(err), .o_irq(irq));
	function automatic logic [11:0] exp_cfg(input logic [7:0] l, input logic [7:0] h);
		return {h[3:0], l};
	endfunction
	task automatic check(input logic [11:0] seen, input logic [11:0] exp);
		n_compared++;
		if (seen !== exp) begin
			err_total++;
			$display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	task automatic conclude();
		$display("compared=%0d errors=%0d", n_compared, err_total);
		if (err_total == 0 && n_compared > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask
	task automatic cmd(input logic [23:0] d, input int n);
		i_host.xfer(d, n);
		repeat (3) @(posedge clk);
	endtask
	initial begin
		clk = 1'b0;
		forever #10 clk = ~clk;
	end
	initial begin
		repeat (20000) @(posedge clk);
		err_total++;
		conclude();
	end
	initial begin
		rst = 1'b1;
		idle = 1'b1;
		err_clr = 1'b0;
		status = 8'h00;
		repeat (20) @(posedge clk);
		rst <= 1'b0;
		@(posedge clk);
		check(cfg, ACC_NV_RESET);
		for (int k = 0; k < 10; k++) begin
			op = k[0] ? ACC_OP_LOAD_REG : ACC_OP_LOAD_PIN;
			lo = 8'($random(seed));
			hi = (k == 9) ? 8'hf3 : 8'($random(seed));
			@(posedge clk) status <= 8'($random(seed)) & 8'hfe;
			cmd({op, lo, hi}, 3);
			check(12'(first), 12'(status));
			check(cfg, exp_cfg(lo, hi));
			check(12'(vfr), 12'(k[0]));
			check(12'(irq), 12'h000);
		end
		cmd({ACC_OP_SAVE, ACC_ARG_ZERO, 8'h00}, 2);
		check(nv, exp_cfg(lo, hi));
		cmd({ACC_OP_LOAD_REG, 16'h810c}, 3);
		cmd({ACC_OP_SAVE, 16'h0100}, 2);
		check(nv, exp_cfg(lo, hi));
		cmd({ACC_OP_RESTORE, ACC_ARG_ZERO, 8'h00}, 2);
		check(cfg, exp_cfg(lo, hi));
		cmd({ACC_OP_LOAD_REG, 16'h810c}, 3);
		@(posedge clk) idle <= 1'b0;
		cmd({ACC_OP_SAVE, ACC_ARG_ZERO, 8'h00}, 2);
		check(12'(err), 12'h001);
		check(nv, exp_cfg(lo, hi));
		@(posedge clk) err_clr <= 1'b1;
		@(posedge clk) err_clr <= 1'b0;
		@(posedge clk) status <= 8'h00;
		check(12'(err), 12'h000);
		cmd({ACC_OP_RESTORE, ACC_ARG_ZERO, 8'h00}, 2);
		check(12'(err), 12'h001);
		check(cfg, 12'hc81);
		@(posedge clk) idle <= 1'b1;
		cmd(24'h000000, 1);
		check(12'(first), 12'h001);
		@(posedge clk) rst <= 1'b1;
		@(posedge clk) rst <= 1'b0;
		@(posedge clk);
		check(cfg, nv);
		check(cfg, ACC_NV_RESET);
		check(12'(err), 12'h000);
		conclude();
	end
endmodule
`default_nettype wire
